// ==== design/tpc_pkg.sv ====
// Package for the T1 PMA configuration register group.
// Assumes a Clause 45 style register access from a management front end.
package tpc_pkg;
    localparam logic [4:0]  DEV_PMA           = 5'h01;
    localparam logic [15:0] ADDR_CAPABILITIES = 16'h0012;
    localparam logic [15:0] ADDR_LINK_CONFIG  = 16'h0834;
    localparam logic [15:0] ADDR_PMA_CONTROL  = 16'h08F6;

    localparam logic [15:0] RST_CAPABILITIES  = 16'h0004;
    localparam logic [15:0] RST_LINK_CONFIG   = 16'h8002;
    localparam logic [15:0] RST_PMA_CONTROL   = 16'h0000;

    // Link configuration fields
    localparam int LC_RESERVED_HI  = 15;
    localparam int LC_ROLE_SELECT  = 14;
    localparam int LC_TYPE_MSB     = 3;
    localparam logic [15:0] LC_WRITE_MASK = 16'h400F;

    // PMA control fields
    localparam int PC_SELF_CLEAR   = 15;
    localparam int PC_TX_OFF       = 14;
    localparam int PC_HIGH_SWING   = 12;
    localparam int PC_SPARE_RW     = 11;
    localparam int PC_ENERGY_EFF   = 10;
    localparam int PC_LOOPBACK     = 0;
    localparam logic [15:0] PC_WRITE_MASK = 16'hDC01;

    localparam logic [3:0] TYPE_FAST      = 4'h0;
    localparam logic [3:0] TYPE_LONG      = 4'h2;
    localparam logic [3:0] TYPE_SHORT     = 4'h3;

    typedef enum logic [1:0] {
        TPC_TYPE_FAST,
        TPC_TYPE_LONG,
        TPC_TYPE_SHORT,
        TPC_TYPE_RSVD
    } tpc_phy_type_t;
endpackage

// ==== design/tpc_type_decode.sv ====
// Decoder for the four-bit PHY type field.
// Assumes the field comes from the link configuration register or the negotiated type.
`timescale 1ns/1ps
module tpc_type_decode
    import tpc_pkg::*;
(
    input  wire logic [3:0]    typeField,
    output tpc_phy_type_t      phyType
);
    always_comb begin
        if (typeField[3] || typeField[2]) begin
            phyType = TPC_TYPE_RSVD;                   // [RQ7]
        end else if (typeField == TYPE_SHORT) begin
            phyType = TPC_TYPE_SHORT;                  // [RQ7]
        end else if (typeField == TYPE_LONG) begin
            phyType = TPC_TYPE_LONG;                   // [RQ7]
        end else if (typeField == TYPE_FAST) begin
            phyType = TPC_TYPE_FAST;                   // [RQ7]
        end else begin
            phyType = TPC_TYPE_RSVD;
        end
    end
endmodule

// ==== design/tpc_config_regs.sv ====
// T1 PMA capability, link configuration and PMA control registers.
// Assumes an MDIO front end that presents decoded Clause 45 accesses as
// one-cycle strobes with device and register address, all on one clock.
//
// Behaviour
// (RQ1) Three registers live in device 0x01 at 0x0012, 0x0834, 0x08F6.
// (RQ2) Capability register is read-only; writes are dropped.
// (RQ3) Capability bit 2 always reads 1: long-reach supported.
// (RQ4) Capability bits 3, 1, 0 always read 0.
// (RQ5) Role-select bit 14: 1 master, 0 slave; reset from straps.
// (RQ6) Role-select applies only with autonegotiation off.
// (RQ7) PHY-type field decodes reserved, short, long, 100 Mb/s codes.
// (RQ8) PHY-type honoured only when autoneg off and forced mode on.
// (RQ9) Transmit-off bit 14 suppresses transmit output; reset 0.
// (RQ10) Bit 12 picks 2.4 V swing, else 1.0 V; reset from straps.
// (RQ11) Swing bit applies only with autonegotiation off.
// (RQ12) Loopback bit 0 loops transmit to receive inside the PMA.
// (RQ13) Reserved bits read reset value; bit 15 of link config reads 1. A written 1 in PMA control bit 15 reads back for one cycle.
`timescale 1ns/1ps
module tpc_config_regs
    import tpc_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          rst_n,
    // Management access
    input  wire logic          mgmtWrite,
    input  wire logic          mgmtRead,
    input  wire logic [4:0]    mgmtDevice,
    input  wire logic [15:0]   mgmtAddr,
    input  wire logic [15:0]   mgmtWdata,
    output logic      [15:0]   mgmtRdata,
    output logic               mgmtHit,
    // Straps, sampled on the first edge after reset release
    input  wire logic          strapMaster,
    input  wire logic          strapHighSwing,
    // Autonegotiation context
    input  wire logic          autonegEnable,
    input  wire logic          forcedLinkEnable,
    input  wire logic          anMaster,
    input  wire logic          anHighSwing,
    input  wire logic [3:0]    anPhyType,
    // Datapath controls
    output logic               roleMaster,
    output logic               highSwing,
    output tpc_phy_type_t      phyType,
    output logic               txOutputOff,
    output logic               energyEfficientEn,
    output logic               pmaLoopback
);
    // Register picked out by a management access
    typedef enum logic [1:0] {
        TPC_SEL_NONE,
        TPC_SEL_CAP,
        TPC_SEL_LINK,
        TPC_SEL_PMA
    } tpc_reg_sel_t;

    // Stored registers
    logic [15:0]   linkCfg_r;
    logic [15:0]   linkCfg_nxt;
    logic [15:0]   pmaCtl_r;
    logic [15:0]   pmaCtl_nxt;
    logic          strapPend_r;
    logic          strapPend_nxt;
    // Read answer
    logic [15:0]   rdata_r;
    logic [15:0]   rdata_nxt;
    logic          hit_r;
    logic          hit_nxt;
    // Registered controls
    logic          roleMaster_r;
    logic          roleMaster_nxt;
    logic          highSwing_r;
    logic          highSwing_nxt;
    logic          txOff_r;
    logic          txOff_nxt;
    logic          eee_r;
    logic          eee_nxt;
    logic          loop_r;
    logic          loop_nxt;
    tpc_phy_type_t phyType_r;
    tpc_phy_type_t phyType_nxt;
    // Access decode
    tpc_reg_sel_t  accSel;
    logic          wrLinkCfg;
    logic          wrPmaCtl;
    logic          rdMapped;
    // Write data merged under the access masks
    logic [15:0]   lcMerged;
    logic [15:0]   pcMerged;
    // Field views and mode selects
    logic          cfgRoleSelect;
    logic [3:0]    cfgPhyType;
    logic          cfgHighSwing;
    logic          cfgTxOff;
    logic          cfgEnergyEff;
    logic          cfgLoopback;
    logic          manualMode;
    logic          forcedType;
    logic [3:0]    typeSel;
    tpc_phy_type_t decodedType;

    function automatic logic isReg(input logic [4:0]  dev,
                                   input logic [15:0] addr,
                                   input logic [15:0] target);
        isReg = (dev == DEV_PMA) && (addr == target);  // [RQ1]
    endfunction

    // Other devices and other addresses select nothing here
    function automatic tpc_reg_sel_t regSelect(input logic [4:0]  dev,
                                               input logic [15:0] addr);
        regSelect = TPC_SEL_NONE;
        if (isReg(dev, addr, ADDR_CAPABILITIES)) begin
            regSelect = TPC_SEL_CAP;
        end else if (isReg(dev, addr, ADDR_LINK_CONFIG)) begin
            regSelect = TPC_SEL_LINK;
        end else if (isReg(dev, addr, ADDR_PMA_CONTROL)) begin
            regSelect = TPC_SEL_PMA;
        end
    endfunction

    // Access decode
    assign accSel    = regSelect(mgmtDevice, mgmtAddr);         // [RQ1]
    assign wrLinkCfg = mgmtWrite && (accSel == TPC_SEL_LINK);
    assign wrPmaCtl  = mgmtWrite && (accSel == TPC_SEL_PMA);
    assign rdMapped  = mgmtRead && (accSel != TPC_SEL_NONE);    // [RQ1]

    // Read-only bits keep their stored value on a write
    for (genvar b = 0; b < 16; b++) begin : g_merge
        assign lcMerged[b] = LC_WRITE_MASK[b] ? mgmtWdata[b]
                                              : linkCfg_r[b];   // [RQ13]
        assign pcMerged[b] = PC_WRITE_MASK[b] ? mgmtWdata[b]
                                              : pmaCtl_r[b];    // [RQ13]
    end

    // Register state
    always_comb begin
        linkCfg_nxt   = linkCfg_r;
        pmaCtl_nxt    = pmaCtl_r;
        strapPend_nxt = 1'b0;
        // Self-clearing reserved bit only stands for one cycle
        pmaCtl_nxt[PC_SELF_CLEAR] = 1'b0;
        if (strapPend_r) begin
            // Straps caught after release, not under async reset
            linkCfg_nxt[LC_ROLE_SELECT] = strapMaster;     // [RQ5]
            pmaCtl_nxt[PC_HIGH_SWING]   = strapHighSwing;  // [RQ10]
        end
        if (wrLinkCfg) begin
            linkCfg_nxt = lcMerged;                        // [RQ13]
        end
        if (wrPmaCtl) begin
            // A written 1 in the self-clearing bit wins for one cycle
            pmaCtl_nxt = pcMerged;                         // [RQ13]
        end
        // Capability register has no storage: writes fall away [RQ2]
        linkCfg_nxt[LC_RESERVED_HI] = 1'b1;                // [RQ13]
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            linkCfg_r   <= RST_LINK_CONFIG;
            pmaCtl_r    <= RST_PMA_CONTROL;
            strapPend_r <= 1'b1;
        end else begin
            linkCfg_r   <= linkCfg_nxt;
            pmaCtl_r    <= pmaCtl_nxt;
            strapPend_r <= strapPend_nxt;
        end
    end

    // Read path; a read that selects nothing answers zero, no hit
    always_comb begin
        rdata_nxt = rdata_r;
        hit_nxt   = 1'b0;
        if (mgmtRead) begin
            hit_nxt = rdMapped;                            // [RQ1]
            unique case (accSel)
                TPC_SEL_CAP: begin
                    rdata_nxt = RST_CAPABILITIES;          // [RQ3] [RQ4]
                end
                TPC_SEL_LINK: begin
                    rdata_nxt = linkCfg_r;
                end
                TPC_SEL_PMA: begin
                    rdata_nxt = pmaCtl_r;
                end
                TPC_SEL_NONE: begin
                    // Unmapped here; other blocks may answer
                    rdata_nxt = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 16'h0000;
            hit_r   <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            hit_r   <= hit_nxt;
        end
    end

    assign mgmtRdata = rdata_r;
    assign mgmtHit   = hit_r;

    // Field views of the stored registers
    assign cfgRoleSelect = linkCfg_r[LC_ROLE_SELECT];
    assign cfgPhyType    = linkCfg_r[LC_TYPE_MSB:0];
    assign cfgHighSwing  = pmaCtl_r[PC_HIGH_SWING];
    assign cfgTxOff      = pmaCtl_r[PC_TX_OFF];
    assign cfgEnergyEff  = pmaCtl_r[PC_ENERGY_EFF];
    assign cfgLoopback   = pmaCtl_r[PC_LOOPBACK];

    // Role, swing and type settings apply only with negotiation off
    assign manualMode = !autonegEnable;                     // [RQ6] [RQ11]
    assign forcedType = manualMode && forcedLinkEnable;     // [RQ8]
    assign typeSel    = forcedType ? cfgPhyType : anPhyType; // [RQ8]

    tpc_type_decode u_decode (
        .typeField (typeSel),
        .phyType   (decodedType)
    );

    // Effective controls, registered so the datapath sees clean levels
    always_comb begin
        roleMaster_nxt = manualMode ? cfgRoleSelect
                                    : anMaster;            // [RQ5] [RQ6]
        highSwing_nxt  = manualMode ? cfgHighSwing
                                    : anHighSwing;         // [RQ10] [RQ11]
        txOff_nxt      = cfgTxOff;                         // [RQ9]
        eee_nxt        = cfgEnergyEff;
        loop_nxt       = cfgLoopback;                      // [RQ12]
        phyType_nxt    = decodedType;                      // [RQ7]
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            roleMaster_r <= 1'b0;
            highSwing_r  <= 1'b0;
            txOff_r      <= 1'b0;
            eee_r        <= 1'b0;
            loop_r       <= 1'b0;
            // Matches the type field's reset code
            phyType_r    <= TPC_TYPE_LONG;
        end else begin
            roleMaster_r <= roleMaster_nxt;
            highSwing_r  <= highSwing_nxt;
            txOff_r      <= txOff_nxt;
            eee_r        <= eee_nxt;
            loop_r       <= loop_nxt;
            phyType_r    <= phyType_nxt;
        end
    end

    assign roleMaster        = roleMaster_r;
    assign highSwing         = highSwing_r;
    assign txOutputOff       = txOff_r;
    assign energyEfficientEn = eee_r;
    assign pmaLoopback       = loop_r;
    assign phyType           = phyType_r;
endmodule

// ==== verif/tpc_config_regs_asserts.sv ====
// Checker for the T1 PMA configuration registers.
// Assumes one clock and the one-cycle read answer.
`timescale 1ns/1ps
module tpc_config_regs_asserts
    import tpc_pkg::*;
(
    input wire logic          clock,
    input wire logic          rst_n,
    input wire logic          mgmtWrite,
    input wire logic          mgmtRead,
    input wire logic [4:0]    mgmtDevice,
    input wire logic [15:0]   mgmtAddr,
    input wire logic [15:0]   mgmtWdata,
    input wire logic [15:0]   mgmtRdata,
    input wire logic          mgmtHit,
    input wire logic          autonegEnable,
    input wire logic          anMaster,
    input wire logic          anHighSwing,
    input wire logic [3:0]    anPhyType,
    input wire logic          roleMaster,
    input wire logic          highSwing,
    input wire tpc_phy_type_t phyType,
    input wire logic          txOutputOff,
    input wire logic          pmaLoopback
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    function automatic tpc_phy_type_t tdec(logic [3:0] c);
        case (c)
            TYPE_FAST:  return TPC_TYPE_FAST;
            TYPE_LONG:  return TPC_TYPE_LONG;
            TYPE_SHORT: return TPC_TYPE_SHORT;
            default:    return TPC_TYPE_RSVD;
        endcase
    endfunction
    sequence s_rd(a);
        mgmtRead && mgmtDevice == DEV_PMA && mgmtAddr == a;
    endsequence
    sequence s_wr(a);
        mgmtWrite && mgmtDevice == DEV_PMA && mgmtAddr == a;
    endsequence
    // Negotiated inputs steady long enough to pass the output register
    sequence s_an_steady;
        (autonegEnable && $stable(anMaster) && $stable(anHighSwing)) [*3];
    endsequence
    a_cap_const:
        assert property (s_rd(ADDR_CAPABILITIES) |=> mgmtHit
            && mgmtRdata == 16'h0004) else $error("capability value");
    a_foreign_dev:
        assert property (mgmtRead && mgmtDevice != DEV_PMA |=> !mgmtHit
            && mgmtRdata == 16'h0000) else $error("foreign device read");
    a_lc_reserved:
        assert property (s_rd(ADDR_LINK_CONFIG) |=> mgmtHit && mgmtRdata[15]
            && mgmtRdata[13:4] == 10'h000) else $error("link cfg reserved");
    a_pc_reserved:
        assert property (s_rd(ADDR_PMA_CONTROL) |=> mgmtHit && !mgmtRdata[13]
            && mgmtRdata[9:1] == 9'h000) else $error("pma ctl reserved");
    a_hit_cause:
        assert property (mgmtHit |-> $past(mgmtRead)
            && $past(mgmtDevice) == DEV_PMA) else $error("hit without read");
    a_an_follow:
        assert property (s_an_steady |-> roleMaster == anMaster
            && highSwing == anHighSwing) else $error("negotiated role/swing");
    a_type_an:
        assert property (autonegEnable && anPhyType != 4'h1
            |=> phyType == tdec($past(anPhyType)))
            else $error("negotiated type");
    a_wr_ctrl:
        assert property (s_wr(ADDR_PMA_CONTROL) |=> ##1
            txOutputOff == $past(mgmtWdata[14], 2)
            && pmaLoopback == $past(mgmtWdata[0], 2)) else $error("pma ctl");
endmodule
bind tpc_config_regs tpc_config_regs_asserts i_chk (.clock, .rst_n,
    .mgmtWrite, .mgmtRead, .mgmtDevice, .mgmtAddr, .mgmtWdata, .mgmtRdata,
    .mgmtHit, .autonegEnable, .anMaster, .anHighSwing, .anPhyType,
    .roleMaster, .highSwing, .phyType, .txOutputOff, .pmaLoopback);

// ==== verif/tpc_mgmt_host.sv ====
// Management host model issuing one-cycle strobes.
// Assumes the bench calls acc between clock edges.
`timescale 1ns/1ps
module tpc_mgmt_host
    import tpc_pkg::*;
(
    input  wire logic  clock,
    output logic       mgmtWrite,
    output logic       mgmtRead,
    output logic [4:0] mgmtDevice,
    output logic [15:0] mgmtAddr,
    output logic [15:0] mgmtWdata
);
    initial {mgmtWrite, mgmtRead, mgmtDevice, mgmtAddr, mgmtWdata} = '0;
    task automatic acc(input logic w, input logic [4:0] d,
                       input logic [15:0] a, input logic [15:0] v);
        if (w && a == ADDR_LINK_CONFIG) v[3:0] = TYPE_LONG;
        @(negedge clock);
        {mgmtWrite, mgmtRead, mgmtDevice, mgmtAddr, mgmtWdata} =
            {w, !w, d, a, v};
        @(negedge clock);
        // Released lines, except the device, must not keep the last value
        {mgmtWrite, mgmtRead, mgmtAddr, mgmtWdata} = {2'b00, ~a, ~v};
    endtask
endmodule

// ==== verif/tb_tpc_config_regs.sv ====
// Self-checking bench for the T1 PMA configuration registers.
// Assumes the host model drives strobes on falling edges.
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
    fails++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_tpc_config_regs
    import tpc_pkg::*;
;
    logic          clock = 1'b0, rst_n = 1'b0, mgmtWrite, mgmtRead, mgmtHit;
    logic          strapM = 1'b0, strapS = 1'b0, anEn = 1'b0, forced = 1'b1;
    logic          anM = 1'b0, anS = 1'b0, roleMaster, highSwing;
    logic          txOff, eeEn, loop;
    logic [3:0]    anT = 4'h0;
    logic [4:0]    mgmtDevice;
    logic [15:0]   mgmtAddr, mgmtWdata, mgmtRdata, w;
    logic [15:0]   mdl [3];
    logic [15:0]   adr [4] = '{16'h0012, 16'h0834, 16'h08F6, 16'h0013};
    tpc_phy_type_t phyType, et;
    int            fails = 0, comparisons = 0, k;
    tpc_mgmt_host i_tpc_mgmt_host (.clock, .mgmtWrite, .mgmtRead,
        .mgmtDevice, .mgmtAddr, .mgmtWdata);
    tpc_config_regs i_tpc_config_regs (.clock, .rst_n, .mgmtWrite,
        .mgmtRead, .mgmtDevice, .mgmtAddr, .mgmtWdata, .mgmtRdata, .mgmtHit,
        .strapMaster(strapM), .strapHighSwing(strapS), .autonegEnable(anEn),
        .forcedLinkEnable(forced), .anMaster(anM), .anHighSwing(anS),
        .anPhyType(anT), .roleMaster, .highSwing, .phyType,
        .txOutputOff(txOff), .energyEfficientEn(eeEn), .pmaLoopback(loop));
    task automatic end_sim();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic acc(input int i, input logic wr, input logic [15:0] v);
        i_tpc_mgmt_host.acc(wr, DEV_PMA, adr[i], v);
        // Hit stands one cycle only: judge it before the next edge
        if (!wr) `CHK("rdata", i < 3 ? mdl[i] : 16'h0000, mgmtRdata)
        if (!wr) `CHK("hit", i < 3, mgmtHit)
        @(negedge clock);
        if (wr && i == 1) mdl[1] = {1'b1, v[14], 10'h000, TYPE_LONG};
        if (wr && i == 2) mdl[2] = v & 16'h5C01;
    endtask
    task automatic chkCtl();
        repeat (2) @(negedge clock);
        `CHK("role", anEn ? anM : mdl[1][14], roleMaster)
        `CHK("swing", anEn ? anS : mdl[2][12], highSwing)
        `CHK("txoff", mdl[2][14], txOff)
        `CHK("eee", mdl[2][10], eeEn)
        `CHK("loop", mdl[2][0], loop)
        et = anT > 3 ? TPC_TYPE_RSVD : anT == 3 ? TPC_TYPE_SHORT :
             anT == 2 ? TPC_TYPE_LONG : TPC_TYPE_FAST;
        if (!anEn && forced) et = TPC_TYPE_LONG;
        // Code 0001 is left undefined, so it is not judged
        if (anT != 4'h1 || (!anEn && forced)) `CHK("type", et, phyType)
    endtask
    initial forever #2.5 clock = ~clock;
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        end_sim();
    end
    initial begin
        k = $urandom(32'h6664);
        {strapM, strapS} = 2'($urandom);
        mdl = '{16'h0004, {1'b1, strapM, 14'h0002}, {3'b000, strapS, 12'h000}};
        repeat (12) @(posedge clock);
        @(negedge clock) rst_n = 1'b1;
        repeat (2) @(negedge clock);
        for (k = 0; k < 4; k++) acc(k, 1'b0, 16'h0000);
        chkCtl();
        i_tpc_mgmt_host.acc(1'b0, 5'h02, 16'h0834, 16'h0000);
        `CHK("foreign", 17'h00000, {mgmtHit, mgmtRdata})
        @(negedge clock);
        for (k = 0; k < 48; k++) begin
            {anEn, forced, anM, anS, anT} = 8'($urandom);
            w = 16'($urandom);
            acc(k % 4, 1'b1, w);
            acc(k % 4, 1'b0, 16'h0000);
            chkCtl();
        end
        anEn = 1'b1;
        for (k = 0; k < 16; k++) begin
            anT = 4'(k);
            chkCtl();
        end
        end_sim();
    end
endmodule
